// ===== src/ncpc_pkg.sv
// Package of constants and types for the node communications packet controller.
package ncpc_pkg;
  // ----------------------------------------------------------------
  // Register offsets within one window.
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_TX_CTRL = 5'h00;
  localparam logic [4:0] OFF_RX_STAT = 5'h04;
  localparam logic [4:0] OFF_OUT_PAY = 5'h08;
  localparam logic [4:0] OFF_OUT_KEY = 5'h0c;
  localparam logic [4:0] OFF_IN_PAY = 5'h10;
  localparam logic [4:0] OFF_IN_KEY = 5'h14;
  localparam logic [4:0] OFF_SPARE = 5'h18;
  localparam logic [4:0] OFF_TEST = 5'h1c;
  // ----------------------------------------------------------------
  // Window bases: buffered and unbuffered.
  // ----------------------------------------------------------------
  localparam logic [31:0] BASE_BUFFERED = 32'h2000_0000;
  localparam logic [31:0] BASE_UNBUFFERED = 32'h1000_0000;
  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int TX_EMPTY_BIT = 31;
  localparam int TX_FULL_BIT = 30;
  localparam int TX_OVR_BIT = 29;
  localparam int RX_RCVD_BIT = 31;
  localparam int RX_PAR_BIT = 30;
  localparam int RX_FRM_BIT = 29;
  localparam int CB_LSB = 16;
  localparam int ROUTE_LSB = 24;
  localparam logic [2:0] ROUTE_RESET = 3'h7;
  // ----------------------------------------------------------------
  // Packet kinds.
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_MULTICAST = 2'b00;
  localparam logic [1:0] KIND_P2P = 2'b01;
  localparam logic [1:0] KIND_NEIGHBOUR = 2'b10;
  localparam int SHORT_BITS = 40;
  localparam int LONG_BITS = 72;

  // Packet carried to or from the router.
  typedef struct packed {
    logic [2:0] route;
    logic [7:0] ctrl;
    logic [31:0] key;
    logic [31:0] payload;
  } ncpc_pkt_s;
endpackage

// ===== src/ncpc_top.sv
// Communications packet controller: APB register set and packet framer.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ncpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_valid,
  output ncpc_pkg::ncpc_pkt_s tx_pkt,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire ncpc_pkg::ncpc_pkt_s rx_pkt,
  input wire logic rx_framing_err,
  output logic buffered_write
);
  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  logic tx_full;
  logic tx_ovr;
  logic [2:0] tx_route;
  logic [7:0] tx_cb;
  logic [15:0] src_id;
  logic [31:0] out_pay;
  logic pay_pending;
  logic rx_rcvd;
  logic rx_par;
  logic rx_frm;
  logic [2:0] rx_route;
  logic [7:0] rx_cb;
  logic [31:0] in_pay;
  logic [31:0] in_key;
  logic test_mode;

  // ----------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------
  // Both windows map the same registers; only upper bits pick the window.
  wire logic hit_buf = (paddr[31:5] == ncpc_pkg::BASE_BUFFERED[31:5]);
  wire logic hit_unbuf = (paddr[31:5] == ncpc_pkg::BASE_UNBUFFERED[31:5]);
  wire logic hit = hit_buf | hit_unbuf;
  wire logic [4:0] off = paddr[4:0];
  wire logic acc = psel & penable & pready;
  wire logic wr = acc & pwrite & hit;
  wire logic rd = acc & ~pwrite & hit;
  wire logic wr_ctrl = wr & (off == ncpc_pkg::OFF_TX_CTRL);
  wire logic wr_stat = wr & (off == ncpc_pkg::OFF_RX_STAT);
  wire logic wr_pay = wr & (off == ncpc_pkg::OFF_OUT_PAY);
  wire logic wr_key = wr & (off == ncpc_pkg::OFF_OUT_KEY);
  wire logic wr_test = wr & (off == ncpc_pkg::OFF_TEST);
  wire logic rd_key = rd & (off == ncpc_pkg::OFF_IN_KEY);
  wire logic wr_inpay = wr & test_mode & (off == ncpc_pkg::OFF_IN_PAY);
  wire logic wr_inkey = wr & test_mode & (off == ncpc_pkg::OFF_IN_KEY);

  // ----------------------------------------------------------------
  // Transmit packet assembly.
  // ----------------------------------------------------------------
  wire logic [1:0] kind = tx_cb[7:6];
  logic [7:0] next_cb;
  logic [31:0] next_key;
  ncpc_pkg::ncpc_pkt_s next_pkt;
  wire logic send_busy = tx_valid & ~tx_ready;

  // Parity is folded in only after every other field is fixed, so it covers
  // the exact control and key bits that leave, payload included when present, but not the route.
  always_comb begin
    next_cb = tx_cb;
    next_cb[7:6] = kind;
    next_cb[1] = pay_pending;
    next_cb[3:2] = 2'b00;
    next_key = pwdata;
    if (kind == ncpc_pkg::KIND_P2P) begin
      next_key = {src_id, pwdata[15:0]};
      next_cb[5:4] = pwdata[17:16];
    end else if (kind == ncpc_pkg::KIND_NEIGHBOUR) begin
      next_cb[4:2] = tx_cb[4:2];
      next_cb[5] = tx_cb[5];
    end else begin
      next_cb[5:4] = tx_cb[5:4];
    end
    next_cb[0] = 1'b0;
    next_cb[0] = ~(^next_cb ^ ^next_key ^ (pay_pending & ^out_pay));
    next_pkt.route = tx_route;
    next_pkt.ctrl = next_cb;
    next_pkt.key = next_key;
    next_pkt.payload = pay_pending ? out_pay : 32'h0000_0000;
  end

  // Launch one packet per key write; a write while one waits is an overrun.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_pkt <= '0;
    end else if (wr_key && !send_busy) begin
      tx_valid <= 1'b1;
      tx_pkt <= next_pkt;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Payload staging: a payload write arms the next key write only, even one lost to an overrun.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pay <= 32'h0000_0000;
      pay_pending <= 1'b0;
    end else if (wr_pay) begin
      out_pay <= pwdata;
      pay_pending <= 1'b1;
    end else if (wr_key) begin
      pay_pending <= 1'b0;
    end
  end

  // Control register and sticky transmit flags; set wins over clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_full <= 1'b0;
      tx_ovr <= 1'b0;
      tx_route <= ncpc_pkg::ROUTE_RESET;
      tx_cb <= 8'h00;
      src_id <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        tx_route <= pwdata[ncpc_pkg::ROUTE_LSB +: 3];
        tx_cb <= pwdata[ncpc_pkg::CB_LSB +: 8];
        src_id <= pwdata[15:0];
      end
      if (wr_key && send_busy) begin
        tx_ovr <= 1'b1;
      end else if (wr_ctrl && !pwdata[ncpc_pkg::TX_OVR_BIT]) begin
        tx_ovr <= 1'b0;
      end
      if (wr_key || send_busy) begin
        tx_full <= 1'b1;
      end else if (wr_ctrl && !pwdata[ncpc_pkg::TX_FULL_BIT]) begin
        tx_full <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive side.
  // ----------------------------------------------------------------
  wire logic rx_par_bad = ~(^{rx_pkt.ctrl, rx_pkt.key}
    ^ (rx_pkt.ctrl[1] & ^rx_pkt.payload));
  wire logic rx_good = rx_valid & ~rx_par_bad & ~rx_framing_err;

  // Received data is captured only on a clean packet, so a corrupt arrival
  // cannot overwrite the last good key that software may not have read yet.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_rcvd <= 1'b0;
      rx_par <= 1'b0;
      rx_frm <= 1'b0;
      rx_route <= 3'h0;
      rx_cb <= 8'h00;
      in_pay <= 32'h0000_0000;
      in_key <= 32'h0000_0000;
    end else begin
      if (rx_good) begin
        rx_rcvd <= 1'b1;
        rx_route <= rx_pkt.route;
        rx_cb <= rx_pkt.ctrl;
        in_key <= rx_pkt.key;
        in_pay <= rx_pkt.payload;
      end else if (rd_key) begin
        rx_rcvd <= 1'b0;
      end else if (wr_inkey) begin
        in_key <= pwdata;
      end else if (wr_inpay) begin
        in_pay <= pwdata;
      end
      if (rx_valid && rx_par_bad) begin
        rx_par <= 1'b1;
      end else if (wr_stat && !pwdata[ncpc_pkg::RX_PAR_BIT]) begin
        rx_par <= 1'b0;
      end
      if (rx_valid && rx_framing_err) begin
        rx_frm <= 1'b1;
      end else if (wr_stat && !pwdata[ncpc_pkg::RX_FRM_BIT]) begin
        rx_frm <= 1'b0;
      end
    end
  end

  // Test register bit 0 opens the read-only receive registers to writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_mode <= 1'b0;
    end else if (wr_test) begin
      test_mode <= pwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // APB read path and ready.
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (off == ncpc_pkg::OFF_TX_CTRL) begin
      rd_mux = {~tx_valid, tx_full, tx_ovr, 2'b00, tx_route, tx_cb, src_id};
    end else if (off == ncpc_pkg::OFF_RX_STAT) begin
      rd_mux = {rx_rcvd, rx_par, rx_frm, 2'b00, rx_route, rx_cb, 16'h0000};
    end else if (off == ncpc_pkg::OFF_IN_PAY) begin
      rd_mux = in_pay;
    end else if (off == ncpc_pkg::OFF_IN_KEY) begin
      rd_mux = in_key;
    end else if (off == ncpc_pkg::OFF_TEST) begin
      rd_mux = {31'h0000_0000, test_mode};
    end
  end

  // One wait state: ready rises in the second access cycle; unmapped errors.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      buffered_write <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata <= (psel & penable & ~pready & ~pwrite & hit) ? rd_mux : 32'h0000_0000;
      if (wr) begin
        buffered_write <= hit_buf;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_launch_pulse: assert property (wr_key && !send_busy |=> tx_valid)
    else $error("Key write did not launch a packet.");
  chk_odd_parity: assert property (tx_valid |-> ^{tx_pkt.ctrl, tx_pkt.key, tx_pkt.payload})
    else $error("Sent packet lacks odd parity.");
  chk_payload_flag: assert property (wr_key && !send_busy |=> tx_pkt.ctrl[1] == $past(pay_pending))
    else $error("Payload flag disagrees with staging.");
  chk_kind_bits: assert property (wr_key && !send_busy |=> tx_pkt.ctrl[7:6] == $past(tx_cb[7:6]))
    else $error("Kind bits wrong.");
  chk_no_payload: assert property (tx_valid && !tx_pkt.ctrl[1] |-> tx_pkt.payload == 0)
    else $error("Short packet carries payload.");
  chk_stamp_zero: assert property (tx_valid && tx_pkt.ctrl[7:6] != 2'b10 |-> tx_pkt.ctrl[3:2] == 0)
    else $error("Time stamp not left clear.");
  chk_rcvd_clear: assert property (rd_key && !rx_good |=> !rx_rcvd)
    else $error("Received flag not cleared by key read.");
  chk_full_sticky: assert property (tx_full && !wr_ctrl |=> tx_full)
    else $error("Full flag dropped without a write.");
  chk_p2p_src: assert property (wr_key && !send_busy && kind == 2'b01 |=> tx_pkt.key[31:16] == $past(src_id))
    else $error("Source id missing.");
  cov_long: cover property (tx_valid && tx_pkt.ctrl[1]);
  cov_short: cover property (tx_valid && !tx_pkt.ctrl[1]);
  cov_rx: cover property (rx_good ##[1:20] rd_key);
endmodule // ncpc_top
`default_nettype wire

// ===== testbench/ncpc_router_model.sv
// Behavioural router model facing the packet controller.
`timescale 1ns/1ps
`default_nettype none
module ncpc_router_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_valid,
  input wire ncpc_pkg::ncpc_pkt_s tx_pkt,
  output logic tx_ready,
  output logic rx_valid,
  output ncpc_pkg::ncpc_pkt_s rx_pkt,
  output logic rx_framing_err,
  output ncpc_pkg::ncpc_pkt_s got_pkt,
  output int got_n
);
  int seed = 32'h1234_5678;
  initial begin
    rx_valid = 1'b0;
    rx_pkt = '0;
    rx_framing_err = 1'b0;
  end
  // Random stalls force the framer to hold its offer; accepted packets are logged.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      got_n <= 0;
    end else begin
      tx_ready <= ($random(seed) & 3) != 0;
      if (tx_valid && tx_ready) begin
        got_pkt <= tx_pkt;
        got_n <= got_n + 1;
      end
    end
  end
  // One-cycle delivery; afterwards the packet lines show the complement, never the old value.
  task automatic send(input ncpc_pkg::ncpc_pkt_s p, input logic ferr);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_pkt <= p;
    rx_framing_err <= ferr;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_pkt <= ~p;
    rx_framing_err <= 1'b0;
  endtask
endmodule // ncpc_router_model
`default_nettype wire

// ===== testbench/node_comms_packet_controller_tb.sv
// Self-checking bench for the packet controller.
`timescale 1ns/1ps
`default_nettype none
module node_comms_packet_controller_tb;
  localparam logic [31:0] U = ncpc_pkg::BASE_UNBUFFERED;
  localparam logic [31:0] B = ncpc_pkg::BASE_BUFFERED;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rdv;
  logic pready, pslverr, tx_valid, tx_ready, rx_valid, rx_ferr, bw, erv;
  ncpc_pkg::ncpc_pkt_s tx_pkt, rx_pkt, got_pkt, p;
  int got_n, i, n_mismatch = 0, checks_done = 0, seed = 32'h34a8_0b26;
  always #20 pclk = ~pclk;
  ncpc_top u_ncpc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_pkt(tx_pkt), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_pkt(rx_pkt), .rx_framing_err(rx_ferr), .buffered_write(bw));
  ncpc_router_model u_ncpc_router_model (.pclk(pclk), .presetn(presetn),
    .tx_valid(tx_valid), .tx_pkt(tx_pkt), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_pkt(rx_pkt), .rx_framing_err(rx_ferr), .got_pkt(got_pkt), .got_n(got_n));
  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Expected control byte; parity goes last so it covers every other bit.
  function automatic logic [7:0] exp_ctrl(input logic [1:0] k, input logic [3:0] m,
      input logic hp, input logic [31:0] key, input logic [31:0] pay);
    logic [7:0] c;
    c = {k, m, hp, 1'b0};
    c[0] = ~(^{c, key, hp ? pay : 32'h0000_0000});
    return c;
  endfunction
  // One APB transfer; held until pready is seen at an edge, failing the run after 50 cycles.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      tally_and_finish;
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sends one packet of kind k and compares what reaches the router.
  task automatic launch(input logic [1:0] k, input logic [3:0] m, input logic hp);
    logic [31:0] key, pay, ek;
    logic [3:0] em;
    int n, n0;
    key = $random(seed);
    pay = $random(seed);
    key[17:16] = m[3:2];
    apb(1'b1, U + ncpc_pkg::OFF_TX_CTRL, {8'h07, k, m, 2'b11, 16'h5a3c});
    if (hp) apb(1'b1, U + ncpc_pkg::OFF_OUT_PAY, pay);
    n0 = got_n;
    apb(1'b1, U + ncpc_pkg::OFF_OUT_KEY, key);
    for (n = 0; n < 100 && got_n == n0; n++) @(posedge pclk);
    if (n == 100) begin
      n_mismatch++;
      tally_and_finish;
    end
    em = (k == ncpc_pkg::KIND_P2P) ? {key[17:16], 2'b00} :
         (k == ncpc_pkg::KIND_NEIGHBOUR) ? m : {m[3:2], 2'b00};
    ek = (k == ncpc_pkg::KIND_P2P) ? {16'h5a3c, key[15:0]} : key;
    check(got_pkt.key, ek);
    check(got_pkt.ctrl, exp_ctrl(k, em, hp, ek, pay));
    if (hp) check(got_pkt.payload, pay);
    else check(got_pkt.payload, 32'h0000_0000);
    check(32'(got_pkt.route), 32'h0000_0007);
    check(tx_valid, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, U + ncpc_pkg::OFF_TX_CTRL, 32'h0000_0000);
    check(rdv[31:29], 3'b100);
    // Every kind meets all sixteen settings of bits 5:2 once each, eight short and eight long.
    for (i = 0; i < 48; i++) launch(2'(i % 3), 4'(i / 3), i[0]);
    apb(1'b0, U + ncpc_pkg::OFF_TX_CTRL, 32'h0000_0000);
    check(rdv[30], 1'b1);
    apb(1'b1, B + ncpc_pkg::OFF_TX_CTRL, 32'h0700_0000);
    @(posedge pclk);
    check(bw, 1'b1);
    apb(1'b0, U + ncpc_pkg::OFF_TX_CTRL, 32'h0000_0000);
    check(rdv[30], 1'b0);
    apb(1'b1, U + ncpc_pkg::OFF_TEST, 32'h0000_0000);
    @(posedge pclk);
    check({bw, erv}, 2'b00);
    apb(1'b0, 32'h3000_0000, 32'h0000_0000);
    check(erv, 1'b1);
    // Reception: clean packet, then bad parity, then a framing error.
    p.route = $random(seed);
    p.key = $random(seed);
    p.payload = $random(seed);
    p.ctrl = exp_ctrl(2'b00, 4'h0, 1'b1, p.key, p.payload);
    u_ncpc_router_model.send(p, 1'b0);
    apb(1'b0, U + ncpc_pkg::OFF_RX_STAT, 32'h0000_0000);
    check(rdv[31:29], 3'b100);
    check({rdv[26:24], rdv[23:16]}, {p.route, p.ctrl});
    apb(1'b0, U + ncpc_pkg::OFF_IN_PAY, 32'h0000_0000);
    check(rdv, p.payload);
    apb(1'b0, U + ncpc_pkg::OFF_IN_KEY, 32'h0000_0000);
    check(rdv, p.key);
    apb(1'b0, U + ncpc_pkg::OFF_RX_STAT, 32'h0000_0000);
    check(rdv[31], 1'b0);
    p.ctrl[0] = ~p.ctrl[0];
    u_ncpc_router_model.send(p, 1'b0);
    apb(1'b0, U + ncpc_pkg::OFF_RX_STAT, 32'h0000_0000);
    check(rdv[31:30], 2'b01);
    u_ncpc_router_model.send(p, 1'b1);
    apb(1'b0, U + ncpc_pkg::OFF_RX_STAT, 32'h0000_0000);
    check({rdv[31], rdv[29]}, 2'b01);
    tally_and_finish;
  end
endmodule // node_comms_packet_controller_tb
`default_nettype wire
